// ===== test/pwmet_stage_model.sv
// Switch driver load that measures the high time of each drive in clocks
`timescale 1ns/10ps
module pwmet_stage_model
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] drv,
    output logic [2:0][7:0] width
);
    logic [2:0][7:0] cnt_r;

    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!aresetn || !drv[i])
                cnt_r[i] <= 8'h00;
            else
                cnt_r[i] <= cnt_r[i] + 8'h01;
            if (!aresetn)
                width[i] <= 8'h00;
            else if (!drv[i] && cnt_r[i] != 8'h00)
                width[i] <= cnt_r[i];
        end
    end
endmodule

// ===== test/tb_pwm_edge_timing_regs.sv
// Self-checking bench for the drive edge timing registers
`timescale 1ns/10ps
module tb_pwm_edge_timing_regs;
import pwmet_pkg::*;
logic aclk, aresetn, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv, ps, da, db, dc;
logic [11:0] awa, ara, mod;
logic [31:0] wd, rd, v;
logic [1:0] br, rr, r;
logic [59:0] et;
logic [2:0][7:0] width;
int errors = 0, n_compared = 0, cyc = 0;
localparam logic [7:0] TV [10] = '{8'h00, 8'h80, 8'h01, 8'h80, 8'h00, 8'hC0, 8'h01, 8'hC0, 8'h01, 8'h00};
localparam pwmet_time_t TE [5] = '{12'h008, 12'h018, 12'h00C, 12'h01C, 12'h010};

pwmet_core #(.PERIOD_INIT(12'h028)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .mod_amount(mod), .period_start(ps), .edge_time(et),
    .first_switch_drive(da), .second_switch_drive(db), .third_switch_drive(dc));
pwmet_stage_model STAGE (.aclk(aclk), .aresetn(aresetn), .drv({dc, db, da}), .width(width));

////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
        errors++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask

task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask

task automatic wrreg(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    awa <= {2'b00, idx, 2'b00};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (awr)
            awv <= 1'b0;
        if (wr)
            wv <= 1'b0;
    end while (bv !== 1'b1);
    rsp = br;
    bready <= 1'b0;
endtask

task automatic rdreg(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    ara <= {2'b00, idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (arr)
            arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    rsp = rr;
    rready <= 1'b0;
endtask

// Edges latch at period start, so let new settings act for a full period first
task automatic chk_edges(input pwmet_time_t a_fall, input logic [7:0] wa_exp);
    int n;
    n = 0;
    repeat (3)
    begin
        n = 0;
        @(posedge aclk);
        while (ps !== 1'b1)
        begin
            @(posedge aclk);
            n++;
        end
    end
    for (int e = 0; e < 5; e++)
        chk("edge_time", 32'(et[12*e +: 12]), 32'(e == 1 ? a_fall : TE[e]));
    chk("width_a", 32'(width[0]), 32'(wa_exp));
    chk("width_b", 32'(width[1]), 32'h0000_0004);
    chk("width_c", 32'(width[2]), 32'h0000_0005);
    chk("period_clocks", 32'(n), 32'h0000_0009);
endtask

////////////////////////////////////////////////////////////////////////////////
initial
begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
end

always @(posedge aclk)
begin
    cyc++;
    if (cyc == 5000)
    begin
        errors++;
        final_report();
    end
end

initial
begin
    {aresetn, awv, wv, bready, arv, rready} = 6'h00;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h0000_0000;
    mod = 12'h004;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
        rdreg(8'(IDX_A_RISE_HI + i), v, r);
        chk("reset_value", v, 32'h0000_0000);
    end
    rdreg(8'h20, v, r);
    chk("unmapped_resp", 32'(r), 32'(RESP_SLVERR));
    rdreg(IDX_PERIOD, v, r);
    chk("period_reset", v, 32'h0000_0028);
    $display("Test reset and map done");
    for (int i = 0; i < 10; i++)
    begin
        wrreg(8'(IDX_A_RISE_HI + i), 32'(TV[i]), r);
        chk("write_resp", 32'(r), 32'(RESP_OKAY));
    end
    for (int i = 0; i < 10; i++)
    begin
        rdreg(8'(IDX_A_RISE_HI + i), v, r);
        chk("readback", v, 32'(TV[i]));
    end
    chk_edges(12'h018, 8'h04);
    $display("Test unmodulated edges done");
    wrreg(IDX_A_FALL_SET, 32'h0000_008C, r);
    chk_edges(12'h01C, 8'h05);
    mod <= 12'h008;
    chk_edges(12'h020, 8'h06);
    $display("Test later edge done");
    wrreg(IDX_A_FALL_SET, 32'h0000_0088, r);
    chk_edges(12'h010, 8'h02);
    $display("Test earlier edge done");
    final_report();
end
endmodule

// ===== verilog/pwmet_core.sv
// Drive edge timing registers, AXI4-Lite slave and period edge generator
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module pwmet_core
    import pwmet_pkg::*;
#(
    parameter int          ADDR_W      = 12,
    parameter pwmet_time_t PERIOD_INIT = PERIOD_RST
)
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic [TIME_W-1:0]        mod_amount,
    output logic                          period_start,
    output logic [N_EDGE*TIME_W-1:0]      edge_time,
    output logic                          first_switch_drive,
    output logic                          second_switch_drive,
    output logic                          third_switch_drive
);

    if (ADDR_W <= IDX_W + 2)
    begin : g_bad_addr
        $error("ADDR_W too small for register map");
    end
    if (PERIOD_INIT <= TICK_UNITS)
    begin : g_bad_period
        $error("PERIOD_INIT must exceed one clock of time counts");
    end

    localparam logic [TIME_W:0] TICK = (TIME_W+1)'(TICK_UNITS);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic              aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [31:0]       w_data_r, w_data_nxt;
    logic [3:0]        w_strb_r, w_strb_nxt;
    logic              awready_r, awready_nxt, wready_r, wready_nxt;
    logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              wr_fire, wr_ok, wr_upper_zero, rd_upper_zero;
    logic [IDX_W-1:0]  wr_idx, rd_idx;

    logic [HI_W-1:0]          time_hi_r [N_EDGE];
    logic [HI_W-1:0]          setting_r [N_EDGE];
    logic [N_EDGE-1:0]        hit_hi, hit_set, fire;
    pwmet_time_t              period_len_r, period_len_nxt;
    pwmet_time_t              phase_r, phase_nxt;
    pwmet_time_t [N_EDGE-1:0] active_r, active_nxt;
    logic [TIME_W:0]          phase_step;
    logic                     wrap;
    logic                     start_r, start_nxt;
    logic                     drv_a_r, drv_a_nxt, drv_b_r, drv_b_nxt, drv_c_r, drv_c_nxt;

    pwmet_edge_if eif ();

    pwmet_edge_calc u_calc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .eif     (eif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign wr_idx        = aw_addr_r[IDX_W+1:2];
    assign rd_idx        = s_axi_araddr[IDX_W+1:2];
    assign wr_upper_zero = (aw_addr_r[ADDR_W-1:IDX_W+2] == '0);
    assign rd_upper_zero = (s_axi_araddr[ADDR_W-1:IDX_W+2] == '0);
    assign wr_fire       = aw_full_r && w_full_r && !bvalid_r;
    assign wr_ok         = wr_upper_zero && ((|hit_hi) || (|hit_set) || (wr_idx == IDX_PERIOD));

    ////////////////////////////////////////////////////////////////////////
    // Per edge registers and edge detection
    for (genvar e = 0; e < N_EDGE; e++)
    begin : g_edge
        logic [HI_W-1:0] hi_nxt;
        logic [HI_W-1:0] set_nxt;
        assign hit_hi[e]  = wr_upper_zero && (wr_idx == HI_IDX[e]);
        assign hit_set[e] = wr_upper_zero && (wr_idx == SET_IDX[e]);
        always_comb
        begin
            hi_nxt  = time_hi_r[e];
            set_nxt = setting_r[e];
            if (wr_fire && w_strb_r[0] && hit_hi[e])
                hi_nxt = w_data_r[HI_W-1:0];
            if (wr_fire && w_strb_r[0] && hit_set[e])
                set_nxt = w_data_r[HI_W-1:0];
        end
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                time_hi_r[e] <= REG_RST;
                setting_r[e] <= REG_RST;
            end
            else
            begin
                time_hi_r[e] <= hi_nxt;
                setting_r[e] <= set_nxt;
            end
        end
        assign eif.base[e]   = {time_hi_r[e], setting_r[e][SET_LO_MSB:SET_LO_LSB]};
        assign eif.mod_en[e] = setting_r[e][SET_MOD_EN_BIT];
        assign eif.sign[e]   = setting_r[e][SET_SIGN_BIT];
        assign fire[e]       = (active_r[e] >= phase_r) && ({1'b0, active_r[e]} < phase_step);
    end
    assign eif.mod_amt = mod_amount;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write and read channels
    always_comb
    begin
        aw_full_nxt    = aw_full_r;
        aw_addr_nxt    = aw_addr_r;
        w_full_nxt     = w_full_r;
        w_data_nxt     = w_data_r;
        w_strb_nxt     = w_strb_r;
        bvalid_nxt     = bvalid_r;
        bresp_nxt      = bresp_r;
        period_len_nxt = period_len_r;
        if (s_axi_awvalid && awready_r)
        begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_full_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (wr_fire)
        begin
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_ok ? RESP_OKAY : RESP_SLVERR;
            aw_full_nxt = 1'b0;
            w_full_nxt  = 1'b0;
            if (wr_upper_zero && (wr_idx == IDX_PERIOD))
            begin
                if (w_strb_r[0])
                    period_len_nxt[HI_W-1:0] = w_data_r[HI_W-1:0];
                if (w_strb_r[1])
                    period_len_nxt[TIME_W-1:HI_W] = w_data_r[TIME_W-1:HI_W];
            end
        end
        awready_nxt = !aw_full_nxt && !bvalid_nxt;
        wready_nxt  = !w_full_nxt && !bvalid_nxt;
    end

    always_comb
    begin
        arready_nxt = arready_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
        if (s_axi_arvalid && arready_r)
        begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rdata_nxt   = '0;
            rresp_nxt   = rd_upper_zero ? RESP_OKAY : RESP_SLVERR;
            if (rd_upper_zero && (rd_idx == IDX_PERIOD))
                rdata_nxt[TIME_W-1:0] = period_len_r;
            else if (rd_upper_zero && (rd_idx == IDX_STATUS))
                rdata_nxt = {4'h0, phase_r, 13'h0000, drv_c_r, drv_b_r, drv_a_r};
            else
            begin
                rresp_nxt = RESP_SLVERR;
                for (int e = 0; e < N_EDGE; e++)
                begin
                    if (rd_upper_zero && (rd_idx == HI_IDX[e]))
                    begin
                        rdata_nxt[HI_W-1:0] = time_hi_r[e];
                        rresp_nxt           = RESP_OKAY;
                    end
                    if (rd_upper_zero && (rd_idx == SET_IDX[e]))
                    begin
                        rdata_nxt[HI_W-1:0] = setting_r[e];
                        rresp_nxt           = RESP_OKAY;
                    end
                end
            end
        end
        // Address taken whenever no answer is pending, but not in the first clock after reset
        arready_nxt = !rvalid_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Period counter in time counts and drive outputs
    always_comb
    begin
        phase_step = {1'b0, phase_r} + TICK;
        wrap       = (phase_step >= {1'b0, period_len_r});
        phase_nxt  = wrap ? '0 : phase_step[TIME_W-1:0];
        active_nxt = wrap ? eif.eff : active_r;
        start_nxt  = wrap;
        drv_a_nxt  = drv_a_r;
        drv_b_nxt  = drv_b_r;
        drv_c_nxt  = drv_c_r;
        if (fire[E_A_RISE])
            drv_a_nxt = 1'b1;
        if (fire[E_A_FALL])
            drv_a_nxt = 1'b0;
        if (fire[E_B_RISE])
            drv_b_nxt = 1'b1;
        if (fire[E_B_FALL])
            drv_b_nxt = 1'b0;
        if (wrap)
            drv_c_nxt = 1'b0;
        if (fire[E_C_RISE])
            drv_c_nxt = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r    <= 1'b0;
            aw_addr_r    <= '0;
            w_full_r     <= 1'b0;
            w_data_r     <= '0;
            w_strb_r     <= '0;
            awready_r    <= 1'b0;
            wready_r     <= 1'b0;
            bvalid_r     <= 1'b0;
            bresp_r      <= RESP_OKAY;
            arready_r    <= 1'b0;
            rvalid_r     <= 1'b0;
            rdata_r      <= '0;
            rresp_r      <= RESP_OKAY;
            period_len_r <= PERIOD_INIT;
            phase_r      <= '0;
            active_r     <= '0;
            start_r      <= 1'b0;
            drv_a_r      <= 1'b0;
            drv_b_r      <= 1'b0;
            drv_c_r      <= 1'b0;
        end
        else
        begin
            aw_full_r    <= aw_full_nxt;
            aw_addr_r    <= aw_addr_nxt;
            w_full_r     <= w_full_nxt;
            w_data_r     <= w_data_nxt;
            w_strb_r     <= w_strb_nxt;
            awready_r    <= awready_nxt;
            wready_r     <= wready_nxt;
            bvalid_r     <= bvalid_nxt;
            bresp_r      <= bresp_nxt;
            arready_r    <= arready_nxt;
            rvalid_r     <= rvalid_nxt;
            rdata_r      <= rdata_nxt;
            rresp_r      <= rresp_nxt;
            period_len_r <= period_len_nxt;
            phase_r      <= phase_nxt;
            active_r     <= active_nxt;
            start_r      <= start_nxt;
            drv_a_r      <= drv_a_nxt;
            drv_b_r      <= drv_b_nxt;
            drv_c_r      <= drv_c_nxt;
        end
    end

    assign s_axi_awready       = awready_r;
    assign s_axi_wready        = wready_r;
    assign s_axi_bvalid        = bvalid_r;
    assign s_axi_bresp         = bresp_r;
    assign s_axi_arready       = arready_r;
    assign s_axi_rvalid        = rvalid_r;
    assign s_axi_rdata         = rdata_r;
    assign s_axi_rresp         = rresp_r;
    assign period_start        = start_r;
    assign edge_time           = active_r;
    assign first_switch_drive  = drv_a_r;
    assign second_switch_drive = drv_b_r;
    assign third_switch_drive  = drv_c_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_hi_store;
        wr_fire && w_strb_r[0] && hit_hi[E_A_FALL]
        |=> time_hi_r[E_A_FALL] == $past(w_data_r[HI_W-1:0]) && s_axi_bvalid;
    endproperty
    a_hi_store: assert property (p_hi_store) else $error("time high byte not stored");

    property p_lo_nibble;
        wr_fire && w_strb_r[0] && hit_set[E_B_RISE]
        |=> eif.base[E_B_RISE][LO_W-1:0] == $past(w_data_r[SET_LO_MSB:SET_LO_LSB]);
    endproperty
    a_lo_nibble: assert property (p_lo_nibble) else $error("low nibble not joined to edge time");

    property p_step;
        !wrap |=> phase_r == $past(phase_step[TIME_W-1:0]) && !period_start;
    endproperty
    a_step: assert property (p_step) else $error("phase did not advance by one clock of counts");

    property p_wrap;
        wrap |=> phase_r == '0 && period_start && active_r == $past(eif.eff);
    endproperty
    a_wrap: assert property (p_wrap) else $error("period restart did not reload edges");

    property p_a_rise;
        fire[E_A_RISE] && !fire[E_A_FALL] |=> first_switch_drive;
    endproperty
    a_a_rise: assert property (p_a_rise) else $error("first drive did not rise");

    property p_a_fall;
        fire[E_A_FALL] |=> !first_switch_drive;
    endproperty
    a_a_fall: assert property (p_a_fall) else $error("first drive did not fall");

    property p_b_rise;
        fire[E_B_RISE] && !fire[E_B_FALL] |=> second_switch_drive;
    endproperty
    a_b_rise: assert property (p_b_rise) else $error("second drive did not rise");

    property p_b_fall;
        fire[E_B_FALL] |=> !second_switch_drive;
    endproperty
    a_b_fall: assert property (p_b_fall) else $error("second drive did not fall");

    property p_c_rise;
        fire[E_C_RISE] |=> third_switch_drive [*1] ##0 $stable(edge_time) or period_start;
    endproperty
    a_c_rise: assert property (p_c_rise) else $error("third drive did not rise");

    c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
    c_read:  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
    c_pulse: cover property (first_switch_drive ##[1:300] !first_switch_drive);
    c_third: cover property (period_start ##[1:300] third_switch_drive);

endmodule

// ===== verilog/pwmet_edge_calc.sv
// Applies loop modulation offset to each programmed edge time
`timescale 1ns/10ps
module pwmet_edge_calc
    import pwmet_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    pwmet_edge_if.calc eif
);

    pwmet_time_t [N_EDGE-1:0] eff_r;
    pwmet_time_t [N_EDGE-1:0] eff_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Saturating offset per edge
    for (genvar e = 0; e < N_EDGE; e++)
    begin : g_edge
        logic [TIME_W:0] later;
        logic [TIME_W:0] earlier;
        assign later   = {1'b0, eif.base[e]} + {1'b0, eif.mod_amt};
        assign earlier = {1'b0, eif.base[e]} - {1'b0, eif.mod_amt};
        always_comb
        begin
            if (!eif.mod_en[e])
                eff_nxt[e] = eif.base[e];
            else if (eif.sign[e])
                eff_nxt[e] = later[TIME_W] ? '1 : later[TIME_W-1:0];
            else
                eff_nxt[e] = earlier[TIME_W] ? '0 : earlier[TIME_W-1:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            eff_r <= '0;
        else
            eff_r <= eff_nxt;
    end

    assign eif.eff = eff_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_no_mod;
        !eif.mod_en[E_A_FALL] |=> eif.eff[E_A_FALL] == $past(eif.base[E_A_FALL]);
    endproperty
    a_no_mod: assert property (p_no_mod) else $error("unmodulated edge moved");

    property p_mod_later;
        eif.mod_en[E_A_FALL] && eif.sign[E_A_FALL]
            && ({1'b0, eif.base[E_A_FALL]} + {1'b0, eif.mod_amt} <= {1'b0, {TIME_W{1'b1}}})
        |=> eif.eff[E_A_FALL] == $past(eif.base[E_A_FALL]) + $past(eif.mod_amt);
    endproperty
    a_mod_later: assert property (p_mod_later) else $error("negative sign edge not moved later");

    property p_mod_earlier;
        eif.mod_en[E_A_FALL] && !eif.sign[E_A_FALL] && (eif.base[E_A_FALL] >= eif.mod_amt)
        |=> eif.eff[E_A_FALL] == $past(eif.base[E_A_FALL]) - $past(eif.mod_amt);
    endproperty
    a_mod_earlier: assert property (p_mod_earlier) else $error("positive sign edge not moved earlier");

endmodule

// ===== verilog/pwmet_edge_if.sv
// Bundle between register core and edge offset calculator
`timescale 1ns/10ps
interface pwmet_edge_if;
    import pwmet_pkg::*;
    pwmet_time_t [N_EDGE-1:0] base;
    logic        [N_EDGE-1:0] mod_en;
    logic        [N_EDGE-1:0] sign;
    pwmet_time_t              mod_amt;
    pwmet_time_t [N_EDGE-1:0] eff;
    modport ctl  (output base, output mod_en, output sign, output mod_amt, input eff);
    modport calc (input base, input mod_en, input sign, input mod_amt, output eff);
endinterface

// ===== verilog/pwmet_pkg.sv
// Shared constants and types for the drive edge timing block
package pwmet_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Edge time format
    localparam int HI_W           = 8;
    localparam int LO_W           = 4;
    localparam int TIME_W         = HI_W + LO_W;
    localparam int SET_LO_MSB     = 7;
    localparam int SET_LO_LSB     = 4;
    localparam int SET_MOD_EN_BIT = 3;
    localparam int SET_SIGN_BIT   = 2;
    localparam int N_EDGE         = 5;

    // Edge slots
    localparam int E_A_RISE = 0;
    localparam int E_A_FALL = 1;
    localparam int E_B_RISE = 2;
    localparam int E_B_FALL = 3;
    localparam int E_C_RISE = 4;

    ////////////////////////////////////////////////////////////////////////
    // Timing: edge resolution and clock period in ns
    localparam int RES_NS     = 5;
    localparam int CLK_NS     = 20;
    localparam int TICK_UNITS = (CLK_NS + RES_NS - 1) / RES_NS;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] IDX_A_RISE_HI  = 8'h41;
    localparam logic [IDX_W-1:0] IDX_A_RISE_SET = 8'h42;
    localparam logic [IDX_W-1:0] IDX_A_FALL_HI  = 8'h43;
    localparam logic [IDX_W-1:0] IDX_A_FALL_SET = 8'h44;
    localparam logic [IDX_W-1:0] IDX_B_RISE_HI  = 8'h45;
    localparam logic [IDX_W-1:0] IDX_B_RISE_SET = 8'h46;
    localparam logic [IDX_W-1:0] IDX_B_FALL_HI  = 8'h47;
    localparam logic [IDX_W-1:0] IDX_B_FALL_SET = 8'h48;
    localparam logic [IDX_W-1:0] IDX_C_RISE_HI  = 8'h49;
    localparam logic [IDX_W-1:0] IDX_C_RISE_SET = 8'h4A;
    localparam logic [IDX_W-1:0] IDX_PERIOD     = 8'h60;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 8'h61;

    localparam logic [IDX_W-1:0] HI_IDX  [N_EDGE] = '{IDX_A_RISE_HI, IDX_A_FALL_HI, IDX_B_RISE_HI,
                                                       IDX_B_FALL_HI, IDX_C_RISE_HI};
    localparam logic [IDX_W-1:0] SET_IDX [N_EDGE] = '{IDX_A_RISE_SET, IDX_A_FALL_SET, IDX_B_RISE_SET,
                                                       IDX_B_FALL_SET, IDX_C_RISE_SET};

    ////////////////////////////////////////////////////////////////////////
    // Reset values, status layout and bus answers
    localparam logic [HI_W-1:0]   REG_RST     = 8'h00;
    localparam logic [TIME_W-1:0] PERIOD_RST  = 12'h03E8;
    localparam int                STAT_PH_LSB = 16;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;

    typedef logic [TIME_W-1:0] pwmet_time_t;

endpackage
